// ==== rtl/serial_port1_pkg.sv ====
// Constants and pin layout for the second serial port pin multiplexer.
// What this block does
// - In asynchronous mode control pin zero carries the receive clock, as input or output.
// - In synchronous mode control pin zero is transmitter 1 output or serial flag 0.
// - Control pin one is the receive frame sync when asynchronous, else transmitter 2 or flag 1.
// - The frame sync pin serves both directions when synchronous and only transmit otherwise.
// - An output frame sync pin carries the internal frame sync; an input one is supplied outside.
// - The bit clock pin carries the bit clock for both directions when synchronous, else transmit.
// - The receive data pin is an input whose bits are shifted into the receive path.
// - The transmit data pin is driven while transmitting with the transmit shift bits.
// - After reset every shared pin is a general-purpose input.
// - A pin in its general-purpose role takes its direction from its direction bit.
// - A pin moves to its serial role when its control bit selects that role.
// - In stop an input pin is ignored and an output pin is released to a keeper at its last level.
// - The wait state leaves every pin unchanged.
package serial_port1_pkg;
  localparam int NUM_PINS = 6;
  localparam int PIN_CTRL_ZERO = 0;
  localparam int PIN_CTRL_ONE = 1;
  localparam int PIN_FRAME_SYNC = 2;
  localparam int PIN_BIT_CLOCK = 3;
  localparam int PIN_RX_DATA = 4;
  localparam int PIN_TX_DATA = 5;
  localparam logic [5:0] PORT_CTRL_RESET = 6'h00;
  localparam logic [5:0] PORT_DIR_RESET = 6'h00;
  localparam logic [5:0] PIN_OE_RESET = 6'h00;
  localparam logic [5:0] PIN_OUT_RESET = 6'h00;
  localparam logic [5:0] KEEPER_RESET = 6'h00;
  localparam logic [1:0] FLAG_RESET = 2'h0;
  localparam int SYNC_STAGES = 2;
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int MIN_HALF_PHASES = 3;
  // Each bit clock half holds three phases, so it is seen in two or more samples.
  localparam int MIN_HALF_CLOCKS = (MIN_HALF_PHASES + 1) / 2;
  localparam int RX_BUF_DEPTH = 2;
  localparam int RX_BIT_WIDTH = 1;
endpackage

// ==== rtl/serial_bit_buffer.sv ====
// Small valid/ready buffer in the receive data path.
`timescale 1ns/1ps
`default_nettype none
module serial_bit_buffer
  import serial_port1_pkg::*;
#(
  parameter int WIDTH = RX_BIT_WIDTH,
  parameter int DEPTH = RX_BUF_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic push;
  logic pop;

  assign in_ready_out = (count != CNT_W'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out = store[rd_ptr];
  assign push = in_valid_in && in_ready_out && clk_en_in;
  assign pop = out_valid_out && out_ready_in && clk_en_in;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      store[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/serial_port1_pin_mux.sv ====
// Pin multiplexer between the second serial port and its general-purpose port.
`timescale 1ns/1ps
`default_nettype none
module serial_port1_pin_mux
  import serial_port1_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic stop_in,
  input wire logic [5:0] pin_in,
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe_out,
  output logic [5:0] keeper_en_out,
  input wire logic [5:0] port_ctrl_in,
  input wire logic [5:0] port_dir_in,
  input wire logic [5:0] gpio_data_in,
  output logic [5:0] gpio_data_out,
  input wire logic async_mode_in,
  input wire logic ctrl_zero_tx_sel_in,
  input wire logic ctrl_one_tx_sel_in,
  input wire logic [1:0] flag_drive_in,
  input wire logic [1:0] flag_level_in,
  input wire logic rx_clock_drive_in,
  input wire logic rx_frame_sync_drive_in,
  input wire logic frame_sync_drive_in,
  input wire logic bit_clock_drive_in,
  input wire logic gen_rx_clock_in,
  input wire logic gen_rx_frame_sync_in,
  input wire logic gen_frame_sync_in,
  input wire logic gen_bit_clock_in,
  input wire logic tx1_bit_in,
  input wire logic tx2_bit_in,
  input wire logic tx_active_in,
  input wire logic tx_bit_in,
  input wire logic rx_enable_in,
  output logic [1:0] flag_sense_out,
  output logic bit_clock_out,
  output logic frame_sync_out,
  output logic rx_frame_sync_out,
  output logic rx_clock_out,
  output logic rx_bit_out,
  output logic rx_bit_valid_out,
  input wire logic rx_bit_ready_in,
  output logic rx_overrun_out
);
  // ----------------------------------------------------------------
  // Configuration capture and pin input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] ctrl_q;
  logic [5:0] dir_q;
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic [5:0] ser_oe;
  logic [5:0] ser_out;
  wire logic [5:0] next_oe;
  wire logic [5:0] next_out;
  logic run;

  assign run = clk_en_in && !stop_in;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ctrl_q <= PORT_CTRL_RESET;
      dir_q <= PORT_DIR_RESET;
    end else if (run) begin
      ctrl_q <= port_ctrl_in;
      dir_q <= port_dir_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      sync_a <= PIN_OUT_RESET;
      sync_b <= PIN_OUT_RESET;
    end else if (clk_en_in) begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // Serial role of each pin
  // ----------------------------------------------------------------
  always_comb begin
    ser_oe = 6'h00;
    ser_out = 6'h00;
    if (async_mode_in) begin
      ser_oe[PIN_CTRL_ZERO] = rx_clock_drive_in;
      ser_out[PIN_CTRL_ZERO] = gen_rx_clock_in;
      ser_oe[PIN_CTRL_ONE] = rx_frame_sync_drive_in;
      ser_out[PIN_CTRL_ONE] = gen_rx_frame_sync_in;
    end else begin
      ser_oe[PIN_CTRL_ZERO] = ctrl_zero_tx_sel_in || flag_drive_in[0];
      ser_out[PIN_CTRL_ZERO] = ctrl_zero_tx_sel_in ? tx1_bit_in : flag_level_in[0];
      ser_oe[PIN_CTRL_ONE] = ctrl_one_tx_sel_in || flag_drive_in[1];
      ser_out[PIN_CTRL_ONE] = ctrl_one_tx_sel_in ? tx2_bit_in : flag_level_in[1];
    end
    ser_oe[PIN_FRAME_SYNC] = frame_sync_drive_in;
    ser_out[PIN_FRAME_SYNC] = gen_frame_sync_in;
    ser_oe[PIN_BIT_CLOCK] = bit_clock_drive_in;
    ser_out[PIN_BIT_CLOCK] = gen_bit_clock_in;
    ser_oe[PIN_RX_DATA] = 1'b0;
    ser_oe[PIN_TX_DATA] = tx_active_in;
    ser_out[PIN_TX_DATA] = tx_bit_in;
  end

  // ----------------------------------------------------------------
  // Per-pin choice between port and serial roles
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    assign next_oe[i] = ctrl_q[i] ? ser_oe[i] : dir_q[i];
    assign next_out[i] = ctrl_q[i] ? ser_out[i] : gpio_data_in[i];
  end

  // The wait state has no input here, so the pins run on unchanged through it.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pin_oe_out <= PIN_OE_RESET;
      pin_out <= PIN_OUT_RESET;
      keeper_en_out <= KEEPER_RESET;
    end else if (clk_en_in) begin
      if (stop_in) begin
        pin_oe_out <= 6'h00;
        keeper_en_out <= keeper_en_out | pin_oe_out;
      end else begin
        pin_oe_out <= next_oe;
        pin_out <= next_out;
        keeper_en_out <= 6'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sensed levels toward the port and the serial logic
  // ----------------------------------------------------------------
  logic rx_clk_src;
  logic rx_clk_prev;
  logic rx_edge;
  logic buf_in_ready;

  assign rx_clk_src = async_mode_in ? sync_b[PIN_CTRL_ZERO] : sync_b[PIN_BIT_CLOCK];

  // Inputs freeze during stop, so an input pin is ignored there.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      gpio_data_out <= PIN_OUT_RESET;
      flag_sense_out <= FLAG_RESET;
      bit_clock_out <= 1'b0;
      frame_sync_out <= 1'b0;
      rx_frame_sync_out <= 1'b0;
      rx_clock_out <= 1'b0;
    end else if (run) begin
      gpio_data_out <= sync_b & ~ctrl_q;
      flag_sense_out <= async_mode_in ? FLAG_RESET : (sync_b[1:0] & ctrl_q[1:0]);
      bit_clock_out <= sync_b[PIN_BIT_CLOCK] && ctrl_q[PIN_BIT_CLOCK];
      frame_sync_out <= sync_b[PIN_FRAME_SYNC] && ctrl_q[PIN_FRAME_SYNC];
      rx_frame_sync_out <= async_mode_in ? (sync_b[PIN_CTRL_ONE] && ctrl_q[PIN_CTRL_ONE])
        : (sync_b[PIN_FRAME_SYNC] && ctrl_q[PIN_FRAME_SYNC]);
      rx_clock_out <= rx_clk_src;
    end
  end

  // ----------------------------------------------------------------
  // Receive data capture on the falling edge of the receive clock
  // ----------------------------------------------------------------
  // Sampling needs the clock halves to span at least two system clocks.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      rx_clk_prev <= 1'b0;
    end else if (run) begin
      rx_clk_prev <= rx_clk_src;
    end
  end

  assign rx_edge = run && rx_enable_in && ctrl_q[PIN_RX_DATA] && rx_clk_prev && !rx_clk_src;

  serial_bit_buffer #(
    .WIDTH(RX_BIT_WIDTH),
    .DEPTH(RX_BUF_DEPTH)
  ) u_rx_buf (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .in_valid_in(rx_edge),
    .in_ready_out(buf_in_ready),
    .in_data_in(sync_b[PIN_RX_DATA]),
    .out_valid_out(rx_bit_valid_out),
    .out_ready_in(rx_bit_ready_in),
    .out_data_out(rx_bit_out)
  );

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      rx_overrun_out <= 1'b0;
    end else if (clk_en_in) begin
      rx_overrun_out <= rx_edge && !buf_in_ready;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_stop_step;
    clk_en_in && stop_in;
  endsequence

  sequence s_stop_pair;
    s_stop_step ##1 s_stop_step;
  endsequence

  a_reset_port_input: assert property (@(posedge ref_clk_in)
    $rose(rst_b_in) |-> (pin_oe_out == 6'h00) && (keeper_en_out == 6'h00))
    else $error("Pins not inputs after reset.");

  a_port_dir_follow: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    run |=> ((pin_oe_out & ~$past(ctrl_q)) == ($past(dir_q) & ~$past(ctrl_q))))
    else $error("Port pin direction does not follow its direction bit.");

  a_serial_role_sel: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    run |=> ((pin_out & $past(ctrl_q)) == ($past(ser_out) & $past(ctrl_q))))
    else $error("Serial role pin level not taken from serial logic.");

  a_dir_bit_ignored: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (run && ctrl_q[PIN_BIT_CLOCK] && dir_q[PIN_BIT_CLOCK] && !bit_clock_drive_in)
    |=> !pin_oe_out[PIN_BIT_CLOCK])
    else $error("Direction bit drives a serial role pin.");

  a_rx_pin_input: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (run && ctrl_q[PIN_RX_DATA]) |=> !pin_oe_out[PIN_RX_DATA])
    else $error("Receive data pin driven.");

  a_rx_bit_stored: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (rx_edge && buf_in_ready) |=> rx_bit_valid_out)
    else $error("Captured receive bit not offered.");

  a_tx_data_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (run && ctrl_q[PIN_TX_DATA] && tx_active_in)
    |=> pin_oe_out[PIN_TX_DATA] && (pin_out[PIN_TX_DATA] == $past(tx_bit_in)))
    else $error("Transmit data pin not driven while transmitting.");

  a_ctrl_zero_async: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (run && ctrl_q[PIN_CTRL_ZERO] && async_mode_in && rx_clock_drive_in)
    |=> pin_oe_out[PIN_CTRL_ZERO] && (pin_out[PIN_CTRL_ZERO] == $past(gen_rx_clock_in)))
    else $error("Control pin zero not carrying receive clock.");

  a_ctrl_zero_sync: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (run && ctrl_q[PIN_CTRL_ZERO] && !async_mode_in && ctrl_zero_tx_sel_in)
    |=> pin_oe_out[PIN_CTRL_ZERO] && (pin_out[PIN_CTRL_ZERO] == $past(tx1_bit_in)))
    else $error("Control pin zero not carrying transmitter 1.");

  a_ctrl_one_sync: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (run && ctrl_q[PIN_CTRL_ONE] && !async_mode_in && !ctrl_one_tx_sel_in && flag_drive_in[1])
    |=> pin_oe_out[PIN_CTRL_ONE] && (pin_out[PIN_CTRL_ONE] == $past(flag_level_in[1])))
    else $error("Control pin one not carrying flag 1.");

  a_frame_sync_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (run && ctrl_q[PIN_FRAME_SYNC] && frame_sync_drive_in)
    |=> pin_oe_out[PIN_FRAME_SYNC] && (pin_out[PIN_FRAME_SYNC] == $past(gen_frame_sync_in)))
    else $error("Frame sync output not driven.");

  a_bit_clock_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    (run && ctrl_q[PIN_BIT_CLOCK] && bit_clock_drive_in)
    |=> pin_oe_out[PIN_BIT_CLOCK] && (pin_out[PIN_BIT_CLOCK] == $past(gen_bit_clock_in)))
    else $error("Bit clock output not driven.");

  a_stop_release: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    s_stop_pair |-> (pin_oe_out == 6'h00) && $stable(pin_out) && $stable(gpio_data_out))
    else $error("Pins not held during stop.");
endmodule
`default_nettype wire

// ==== testbench/serial_peer.sv ====
// Far-side serial peer that clocks words into the receive pins.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic go_in,
  input wire logic slow_in,
  input wire logic [3:0] word_in,
  output logic clk_out,
  output logic data_out,
  output logic busy_out
);
  initial begin
    clk_out = 1'b0;
    data_out = 1'b0;
    busy_out = 1'b0;
  end
  // The clock stands low between frames and each half lasts at least 80 ns.
  always @(posedge go_in) begin
    busy_out = 1'b1;
    for (int i = 3; i >= 0; i--) begin
      data_out = word_in[i];
      #40 clk_out = 1'b1;
      #80 clk_out = 1'b0;
      #40;
      if (slow_in) #80;
    end
    // A released data line shows the inverse of its last bit.
    data_out = ~data_out;
    busy_out = 1'b0;
  end
endmodule
`default_nettype wire

// ==== testbench/test_serial_port1_pin_mux.sv ====
// Self-checking bench for the serial port pin multiplexer.
`timescale 1ns/1ps
`default_nettype none
module test_serial_port1_pin_mux;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic stop, async_m, sel0, sel1, rxcd, rxfd, fsd, bcd, g_rxc, g_rxf, g_fs, g_bc;
  logic tx1, tx2, txa, txb, rxen, rdy, go, slow, pk_clk, pk_data, pk_busy, ovr, cen;
  logic [5:0] ctrl, dir, gdat, ext, pad, oe, po, keep, gout;
  logic [1:0] fdrv, flev, fsense;
  logic [3:0] word;
  logic bco, fso, rfso, rco, rbit, rval, rovr;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  assign pad = ((oe | keep) & po) | (~(oe | keep) & {ext[5], pk_data, pk_clk, ext[2:0]});
  serial_port1_pin_mux DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .clk_en_in(cen),
    .stop_in(stop), .pin_in(pad), .pin_out(po), .pin_oe_out(oe), .keeper_en_out(keep),
    .port_ctrl_in(ctrl), .port_dir_in(dir), .gpio_data_in(gdat), .gpio_data_out(gout),
    .async_mode_in(async_m), .ctrl_zero_tx_sel_in(sel0), .ctrl_one_tx_sel_in(sel1),
    .flag_drive_in(fdrv), .flag_level_in(flev), .rx_clock_drive_in(rxcd),
    .rx_frame_sync_drive_in(rxfd), .frame_sync_drive_in(fsd), .bit_clock_drive_in(bcd),
    .gen_rx_clock_in(g_rxc), .gen_rx_frame_sync_in(g_rxf), .gen_frame_sync_in(g_fs),
    .gen_bit_clock_in(g_bc), .tx1_bit_in(tx1), .tx2_bit_in(tx2), .tx_active_in(txa),
    .tx_bit_in(txb), .rx_enable_in(rxen), .flag_sense_out(fsense), .bit_clock_out(bco),
    .frame_sync_out(fso), .rx_frame_sync_out(rfso), .rx_clock_out(rco), .rx_bit_out(rbit),
    .rx_bit_valid_out(rval), .rx_bit_ready_in(rdy), .rx_overrun_out(rovr));
  serial_peer peer (.go_in(go), .slow_in(slow), .word_in(word), .clk_out(pk_clk),
    .data_out(pk_data), .busy_out(pk_busy));
  always @(posedge ref_clk_in) begin
    if (rovr === 1'b1) ovr = 1'b1;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("MISMATCH at %0t: run did not finish", $time);
      report_and_stop();
    end
  end
  task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk6({5'h00, got}, {5'h00, exp});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic pop();
    rdy = 1'b1;
    wait_n(1);
    rdy = 1'b0;
  endtask
  task automatic frame(input logic [3:0] w, input logic s);
    int k = 0;
    word = w;
    slow = s;
    go = 1'b1;
    wait_n(1);
    go = 1'b0;
    while (pk_busy === 1'b1 && k < 300) begin
      wait_n(1);
      k++;
    end
    if (k == 300) chk1(1'b1, 1'b0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_gpio();
    dir = 6'h15;
    gdat = 6'h11;
    ext = 6'h22;
    wait_n(6);
    chk6(oe, 6'h15);
    chk6(po & 6'h15, 6'h11);
    chk6(gout, 6'h33);
    // With the clock enable low the new direction must not reach the pins.
    cen = 1'b0;
    dir = 6'h00;
    wait_n(3);
    chk6(oe, 6'h15);
    cen = 1'b1;
  endtask
  task automatic t_tx_stop();
    ctrl = 6'h20;
    dir = 6'h00;
    txa = 1'b1;
    txb = 1'b1;
    wait_n(3);
    chk1(oe[5], 1'b1);
    chk1(po[5], 1'b1);
    txa = 1'b0;
    dir = 6'h20;
    wait_n(3);
    chk1(oe[5], 1'b0);
    txa = 1'b1;
    wait_n(3);
    stop = 1'b1;
    ext[1] = 1'b0;
    wait_n(4);
    chk6(oe, 6'h00);
    chk6(keep, 6'h20);
    chk1(po[5], 1'b1);
    chk1(gout[1], 1'b1);
    stop = 1'b0;
    txa = 1'b0;
  endtask
  task automatic t_flags();
    ctrl = 6'h03;
    dir = 6'h00;
    sel0 = 1'b1;
    tx1 = 1'b1;
    fdrv = 2'b10;
    flev = 2'b10;
    wait_n(3);
    chk6(oe, 6'h03);
    chk6(po & 6'h03, 6'h03);
    sel1 = 1'b1;
    fdrv = 2'b00;
    wait_n(2);
    chk6(oe, 6'h03);
    chk6(po & 6'h03, 6'h01);
    sel0 = 1'b0;
    sel1 = 1'b0;
    ext[1:0] = 2'b10;
    wait_n(5);
    chk6(oe, 6'h00);
    chk6({4'h0, fsense}, 6'h02);
  endtask
  task automatic t_async();
    async_m = 1'b1;
    rxcd = 1'b1;
    g_rxc = 1'b1;
    rxfd = 1'b1;
    wait_n(3);
    chk6(oe, 6'h03);
    chk6(po & 6'h03, 6'h01);
    rxcd = 1'b0;
    rxfd = 1'b0;
    ext[1:0] = 2'b11;
    wait_n(5);
    chk1(rco, 1'b1);
    chk1(rfso, 1'b1);
    async_m = 1'b0;
  endtask
  task automatic t_fsync();
    ctrl = 6'h0c;
    dir = 6'h08;
    fsd = 1'b1;
    g_fs = 1'b1;
    bcd = 1'b1;
    g_bc = 1'b1;
    ext[1] = 1'b0;
    wait_n(3);
    chk6(oe, 6'h0c);
    chk6(po & 6'h0c, 6'h0c);
    wait_n(2);
    chk1(bco, 1'b1);
    fsd = 1'b0;
    bcd = 1'b0;
    ext[2] = 1'b1;
    wait_n(5);
    chk1(fso, 1'b1);
    chk1(rfso, 1'b1);
    chk1(bco, 1'b0);
    chk6(oe, 6'h00);
  endtask
  task automatic t_rx();
    ctrl = 6'h18;
    rxen = 1'b1;
    ovr = 1'b0;
    wait_n(4);
    frame(4'hb, 1'b0);
    wait_n(4);
    chk1(ovr, 1'b1);
    chk1(rval, 1'b1);
    chk1(rbit, 1'b1);
    pop();
    chk1(rbit, 1'b0);
    pop();
    chk1(rval, 1'b0);
    ovr = 1'b0;
    rdy = 1'b1;
    frame(4'h5, 1'b1);
    wait_n(4);
    chk1(ovr, 1'b0);
    rdy = 1'b0;
  endtask
  initial begin
    {stop, async_m, sel0, sel1, rxcd, rxfd, fsd, bcd, g_rxc, g_rxf, g_fs, g_bc} = 12'h000;
    {tx1, tx2, txa, txb, rxen, rdy, go, slow, ovr} = 9'h000;
    cen = 1'b1;
    {ctrl, gdat, ext, fdrv, flev, word} = 26'h000_0000;
    dir = 6'h3f;
    wait_n(4);
    rst_b_in = 1'b1;
    chk6(oe, 6'h00);
    chk6(keep, 6'h00);
    t_gpio();
    t_tx_stop();
    t_flags();
    t_async();
    t_fsync();
    t_rx();
    report_and_stop();
  end
endmodule
`default_nettype wire
